// file: inc/iqcab_pkg.sv
// constants for the AB correction register bank and its datapath
// assumes a 32-bit AHB-Lite slave with one register per aligned word
package iqcab_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IQCAB_IDX_A_GAIN   = 6'h0c;
  localparam logic [5:0] IQCAB_IDX_B_GAIN   = 6'h0d;
  localparam logic [5:0] IQCAB_IDX_DLY_GAIN = 6'h0f;
  localparam logic [5:0] IQCAB_IDX_PHASE    = 6'h10;
  localparam logic [5:0] IQCAB_IDX_SYNC_EN  = 6'h1e;
  localparam logic [5:0] IQCAB_IDX_NONE     = 6'h3f;
  // field positions
  localparam int IQCAB_AB_LAG_LSB = 14;
  localparam int IQCAB_CD_LAG_LSB = 12;
  localparam int IQCAB_GAIN_W     = 11;
  localparam int IQCAB_PHASE_W    = 12;
  localparam int IQCAB_GAIN_FRAC  = 10;
  localparam int IQCAB_PHASE_FRAC = 12;
  // reset values
  localparam logic [15:0] IQCAB_DLY_GAIN_RST = 16'h0400;
  localparam logic [10:0] IQCAB_GAIN_RST     = 11'h400;
  localparam logic [11:0] IQCAB_PHASE_RST    = 12'h000;
  localparam logic        IQCAB_SYNC_EN_RST  = 1'b1;
  // sample limits
  localparam logic signed [15:0] IQCAB_SMAX = 16'sh7fff;
  localparam logic signed [15:0] IQCAB_SMIN = 16'sh8000;
  localparam int IQCAB_LAG_MAX = 3;
endpackage : iqcab_pkg

// file: hdl/iqcab_top.sv
// AB correction register bank with gain, phase and pair-lag datapath
// assumes an AHB-Lite master and a valid/ready sample source and sink
//
// Operation
// - AB pair output lag 0..3 accepted sample sets from bits 15:14 of delay/gain register.
// - CD pair output lag 0..3 accepted sample sets from bits 13:12 of delay/gain register.
// - channel D scaled by unsigned 11-bit gain in bits 10:0, 0 to 1.9990.
// - gain words are fixed point, bit 10 weighs one.
// - AB phase word is 12-bit two's complement spanning -0.5 to 0.49975.
// - AB phase word is zero after reset, no correction applied.
// - phase word times B sample is added into A sample.
// - phase register write with auto-sync enabled raises a sync event.
// - sync event loads A gain, B gain and phase together.
// - A and B gain writes stay pending until the sync load.
// - channel A gain is unsigned 11-bit word in bits 10:0 of own register.
// - channel B gain is unsigned 11-bit word in bits 10:0 of own register.
//
// Our own choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module iqcab_top
  import iqcab_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic          CLK_SYS,
  input  wire logic          RST_N,
  input  wire logic          HSEL,
  input  wire logic [31:0]   HADDR,
  input  wire logic [1:0]    HTRANS,
  input  wire logic          HWRITE,
  input  wire logic [2:0]    HSIZE,
  input  wire logic [31:0]   HWDATA,
  input  wire logic          HREADY,
  output logic               HREADYOUT,
  output logic [31:0]        HRDATA,
  output logic               HRESP,
  input  wire logic          IN_VALID,
  output logic               IN_READY,
  input  wire logic [DW-1:0] IN_A,
  input  wire logic [DW-1:0] IN_B,
  input  wire logic [DW-1:0] IN_C,
  input  wire logic [DW-1:0] IN_D,
  output logic               OUT_VALID,
  input  wire logic          OUT_READY,
  output logic [DW-1:0]      OUT_A,
  output logic [DW-1:0]      OUT_B,
  output logic [DW-1:0]      OUT_C,
  output logic [DW-1:0]      OUT_D
);

  // saturate a wide signed sum to one sample
  function automatic logic signed [DW-1:0] f_sat(input logic signed [28:0] v);
    if (v > IQCAB_SMAX) return IQCAB_SMAX;
    if (v < IQCAB_SMIN) return IQCAB_SMIN;
    return v[DW-1:0];
  endfunction

  // unsigned gain times signed sample, binary point below bit 10
  function automatic logic signed [28:0] f_gain(input logic signed [DW-1:0] s,
                                                input logic [10:0] g);
    logic signed [28:0] p;
    p = 29'(s) * $signed({1'b0, g});
    return p >>> IQCAB_GAIN_FRAC;
  endfunction

  logic [5:0]  idx_reg;
  logic        wr_reg;
  logic [15:0] dly_gain_reg;
  logic [10:0] ga_reg;
  logic [10:0] gb_reg;
  logic [11:0] phase_reg;
  logic        sync_en_reg;
  logic [10:0] act_ga_reg;
  logic [10:0] act_gb_reg;
  logic [11:0] act_phase_reg;
  logic        wr_phase;
  logic        sync_load;
  logic [5:0]  rd_idx;
  logic [31:0] rd_next;
  logic [1:0]  lag_ab;
  logic [1:0]  lag_cd;
  logic [10:0] gain_d;

  assign lag_ab = dly_gain_reg[IQCAB_AB_LAG_LSB +: 2];
  assign lag_cd = dly_gain_reg[IQCAB_CD_LAG_LSB +: 2];
  assign gain_d = dly_gain_reg[IQCAB_GAIN_W-1:0];
  assign wr_phase = wr_reg && (idx_reg == IQCAB_IDX_PHASE);
  assign sync_load = wr_phase && sync_en_reg;

  // address phase capture; zero wait states so hready is always high
  assign rd_idx = (HADDR[31:8] == 24'h000000) ? HADDR[7:2] : IQCAB_IDX_NONE;
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      idx_reg   <= IQCAB_IDX_NONE;
      wr_reg    <= 1'b0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      if (HREADY) begin
        idx_reg <= rd_idx;
        wr_reg  <= HSEL && HTRANS[1] && HWRITE;
      end
    end
  end

  // read mux; unmapped and reserved bits read zero
  always_comb begin
    rd_next = 32'h00000000;
    case (rd_idx)
      IQCAB_IDX_A_GAIN:   rd_next[10:0] = ga_reg;
      IQCAB_IDX_B_GAIN:   rd_next[10:0] = gb_reg;
      IQCAB_IDX_DLY_GAIN: rd_next[15:0] = {dly_gain_reg[15:12], 1'b0, dly_gain_reg[10:0]};
      IQCAB_IDX_PHASE:    rd_next[11:0] = phase_reg;
      IQCAB_IDX_SYNC_EN:  rd_next[0]    = sync_en_reg;
      default:            rd_next       = 32'h00000000;
    endcase
  end

  // read data registered at the address phase, stands in the data phase
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      HRDATA <= 32'h00000000;
    end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      HRDATA <= rd_next;
    end
  end

  // software-visible registers written in the data phase
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      dly_gain_reg <= IQCAB_DLY_GAIN_RST;
      ga_reg       <= IQCAB_GAIN_RST;
      gb_reg       <= IQCAB_GAIN_RST;
      phase_reg    <= IQCAB_PHASE_RST;
      sync_en_reg  <= IQCAB_SYNC_EN_RST;
    end else if (wr_reg) begin
      case (idx_reg)
        IQCAB_IDX_A_GAIN:   ga_reg <= HWDATA[IQCAB_GAIN_W-1:0];
        IQCAB_IDX_B_GAIN:   gb_reg <= HWDATA[IQCAB_GAIN_W-1:0];
        IQCAB_IDX_DLY_GAIN: dly_gain_reg <= {HWDATA[15:12], 1'b0, HWDATA[10:0]};
        IQCAB_IDX_PHASE:    phase_reg <= HWDATA[IQCAB_PHASE_W-1:0];
        IQCAB_IDX_SYNC_EN:  sync_en_reg <= HWDATA[0];
        default:            ;
      endcase
    end
  end

  // active AB settings; only the sync load moves them, all in one step
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      act_ga_reg    <= IQCAB_GAIN_RST;
      act_gb_reg    <= IQCAB_GAIN_RST;
      act_phase_reg <= IQCAB_PHASE_RST;
    end else if (sync_load) begin
      act_ga_reg    <= ga_reg;
      act_gb_reg    <= gb_reg;
      act_phase_reg <= HWDATA[IQCAB_PHASE_W-1:0];
    end
  end

  // correction of one sample set
  logic signed [DW-1:0] corr [4];
  logic signed [28:0]   ph_term;
  logic signed [28:0]   a_sum;
  logic [DW-1:0]        tap [4];
  logic                 push;
  logic                 pop;

  // phase word over 4096 spans -0.5 .. 0.49975
  assign ph_term = (29'($signed(act_phase_reg)) * 29'($signed(IN_B))) >>> IQCAB_PHASE_FRAC;
  assign a_sum   = f_gain($signed(IN_A), act_ga_reg) + ph_term;
  assign corr[0] = f_sat(a_sum);
  assign corr[1] = f_sat(f_gain($signed(IN_B), act_gb_reg));
  assign corr[2] = $signed(IN_C);
  assign corr[3] = f_sat(f_gain($signed(IN_D), gain_d));

  assign push = IN_VALID && IN_READY;
  assign pop  = OUT_VALID && OUT_READY;

  // per-channel lag line; a lag step is one accepted sample set
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_lag
      logic [DW-1:0] line_reg [IQCAB_LAG_MAX];
      logic [1:0]    lag;
      assign lag = (ch < 2) ? lag_ab : lag_cd;
      assign tap[ch] = (lag == 2'h0) ? corr[ch] : line_reg[lag - 2'h1];
      always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          for (int i = 0; i < IQCAB_LAG_MAX; i++) line_reg[i] <= '0;
        end else if (push) begin
          line_reg[0] <= corr[ch];
          for (int i = 1; i < IQCAB_LAG_MAX; i++) line_reg[i] <= line_reg[i-1];
        end
      end
    end
  endgenerate

  // two-entry shift buffer; head always in slot 0 so outputs are flops
  logic [4*DW-1:0] ent1_reg;
  logic [4*DW-1:0] wdat;
  logic [1:0]      cnt_reg;
  logic [1:0]      cnt_next;

  assign wdat = {tap[0], tap[1], tap[2], tap[3]};

  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) cnt_next = cnt_reg + 2'h1;
    if (pop && !push) cnt_next = cnt_reg - 2'h1;
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      cnt_reg   <= 2'h0;
      OUT_VALID <= 1'b0;
      IN_READY  <= 1'b1;
    end else begin
      cnt_reg   <= cnt_next;
      OUT_VALID <= cnt_next != 2'h0;
      IN_READY  <= cnt_next != 2'h2; // stall reaches the source
    end
  end

  // buffer slots; slot 0 drives the output ports directly
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      {OUT_A, OUT_B, OUT_C, OUT_D} <= '0;
      ent1_reg <= '0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_reg == 2'h0) {OUT_A, OUT_B, OUT_C, OUT_D} <= wdat;
          else ent1_reg <= wdat;
        end
        2'b01: {OUT_A, OUT_B, OUT_C, OUT_D} <= ent1_reg;
        2'b11: begin
          if (cnt_reg == 2'h1) begin
            {OUT_A, OUT_B, OUT_C, OUT_D} <= wdat;
          end else begin
            {OUT_A, OUT_B, OUT_C, OUT_D} <= ent1_reg;
            ent1_reg <= wdat;
          end
        end
        default: ;
      endcase
    end
  end

  // checks on the datapath and register bank
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  a_ab_lag_one: assert property (
    (push && lag_ab == 2'h1) ##1 (push && lag_ab == 2'h1) |-> tap[0] == $past(corr[0]))
    else $error("ab lag of one cycle wrong");
  a_cd_lag_two: assert property (
    (push && lag_cd == 2'h2) ##1 push [*2] ##0 (lag_cd == 2'h2)
      |-> tap[3] == $past(corr[3], 2))
    else $error("cd lag of two cycles wrong");
  a_dgain_zero: assert property (
    gain_d == 11'h000 |-> corr[3] == 16'sh0000)
    else $error("zero d gain passes data");
  a_unity_gain: assert property (
    gain_d == 11'h400 |-> corr[3] == $signed(IN_D))
    else $error("unity d gain not one");
  a_phase_half: assert property (
    act_phase_reg == 12'h800 && act_ga_reg == 11'h400 && IN_A == 16'h0000
      && IN_B == 16'h0100 |-> corr[0] == 16'shff80)
    else $error("phase -0.5 scale wrong");
  a_phase_reset: assert property (
    $rose(RST_N) |-> act_phase_reg == 12'h000 && phase_reg == 12'h000)
    else $error("phase not zero after reset");
  a_phase_none: assert property (
    act_phase_reg == 12'h000 && act_ga_reg == 11'h400 |-> corr[0] == $signed(IN_A))
    else $error("zero phase alters a");
  a_sync_load: assert property (
    wr_phase && sync_en_reg |=> act_phase_reg == $past(HWDATA[11:0]))
    else $error("sync write did not load phase");
  a_sync_gains: assert property (
    sync_load |=> act_ga_reg == $past(ga_reg) && act_gb_reg == $past(gb_reg))
    else $error("gains not loaded with phase");
  a_gain_pending: assert property (
    !sync_load |=> $stable(act_ga_reg) && $stable(act_gb_reg) && $stable(act_phase_reg))
    else $error("active settings moved without sync");
  a_again_zero: assert property (
    act_ga_reg == 11'h000 && act_phase_reg == 12'h000 |-> corr[0] == 16'sh0000)
    else $error("zero a gain passes data");
  a_bgain_unity: assert property (
    act_gb_reg == 11'h400 |-> corr[1] == $signed(IN_B))
    else $error("unity b gain not one");

  c_sync_load: cover property (sync_load);
  c_buf_full: cover property (cnt_reg == 2'h2 && !IN_READY);
  c_lag_three: cover property (push && lag_ab == 2'h3 && lag_cd == 2'h3);

endmodule // iqcab_top
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the AB correction bank and its sample path
// assumes iqcab_top with an AHB-Lite slave and valid/ready sample ports
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import iqcab_pkg::*;
  logic        clk, rst_n, hsel, hwrite, in_valid, in_ready, out_valid, out_ready;
  logic        hreadyout, hresp, rd_dp, stall, fixed;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] ia, ib, ic, id, oa, ob, oc, od;
  logic [15:0] mreg [64];
  logic [5:0]  regs [6] = '{IQCAB_IDX_A_GAIN, IQCAB_IDX_B_GAIN, IQCAB_IDX_DLY_GAIN,
                            IQCAB_IDX_PHASE, IQCAB_IDX_SYNC_EN, IQCAB_IDX_NONE};
  logic [31:0] rq [$];
  logic [63:0] sq [$];
  logic [63:0] hist [$];
  int          bad_count, cmp_count, ga, gb, ph;

  iqcab_top dut (.CLK_SYS(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp), .IN_VALID(in_valid),
    .IN_READY(in_ready), .IN_A(ia), .IN_B(ib), .IN_C(ic), .IN_D(id), .OUT_VALID(out_valid),
    .OUT_READY(out_ready), .OUT_A(oa), .OUT_B(ob), .OUT_C(oc), .OUT_D(od));

  task automatic cmp32(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp64(input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  function automatic logic [15:0] sat(input longint v);
    return (v > 32767) ? 16'h7fff : (v < -32768) ? 16'h8000 : v[15:0];
  endfunction

  // one single AHB transfer; the model mirrors the bank as the write lands
  task automatic ahb(input logic w, input logic [5:0] idx, input logic [15:0] d);
    logic mapped;
    mapped = idx inside {IQCAB_IDX_A_GAIN, IQCAB_IDX_B_GAIN, IQCAB_IDX_DLY_GAIN,
                         IQCAB_IDX_PHASE, IQCAB_IDX_SYNC_EN};
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, idx, 2'b00};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {16'h0, d};
    if (!w) begin
      rq.push_back(mapped ? {16'h0, mreg[idx]} : 32'h0);
      rd_dp <= 1'b1;
    end else if (mapped) begin
      mreg[idx] = d;
      if (idx == IQCAB_IDX_PHASE && mreg[IQCAB_IDX_SYNC_EN][0]) begin
        ga = mreg[IQCAB_IDX_A_GAIN];
        gb = mreg[IQCAB_IDX_B_GAIN];
        ph = int'($signed(d[11:0]));
      end
    end
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
  endtask

  // low bits cleared so every scaled product is exact, no rounding ambiguity;
  // sets go back to back with valid held high, so lag lines see consecutive takes
  // called right after a clock edge; valid drops only after the last set
  task automatic send(input int cnt);
    logic [15:0] a, b, c, d;
    logic [63:0] cs, pa, pc;
    int          n, lab, lcd, gd;
    for (int k = 0; k < cnt; k++) begin
      a = 16'($urandom) & 16'hfffc;
      b = 16'($urandom) & 16'hfffc;
      c = 16'($urandom);
      d = 16'($urandom) & 16'hfffc;
      // fixed corner: zero A, small B, so the phase term stands alone
      if (fixed) begin
        a = 16'h0000;
        b = 16'h0100;
      end
      in_valid <= 1'b1;
      ia <= a;
      ib <= b;
      ic <= c;
      id <= d;
      do @(posedge clk); while (in_ready !== 1'b1);
      gd = mreg[IQCAB_IDX_DLY_GAIN][10:0];
      cs[63:48] = sat(longint'($signed(a)) * ga / 1024 + longint'($signed(b)) * ph / 4096);
      cs[47:32] = sat(longint'($signed(b)) * gb / 1024);
      cs[31:16] = c;
      cs[15:0] = sat(longint'($signed(d)) * gd / 1024);
      hist.push_back(cs);
      n = hist.size();
      lab = mreg[IQCAB_IDX_DLY_GAIN][15:14];
      lcd = mreg[IQCAB_IDX_DLY_GAIN][13:12];
      pa = (n > lab) ? hist[n-1-lab] : 64'h0;
      pc = (n > lcd) ? hist[n-1-lcd] : 64'h0;
      sq.push_back({pa[63:32], pc[31:0]});
    end
    in_valid <= 1'b0;
  endtask

  task automatic drain();
    repeat (200) if (sq.size() != 0) @(posedge clk);
  endtask

  task automatic final_report();
    // results still owed at the end mean a lost or stuck output
    if (sq.size() != 0 || rq.size() != 0) begin
      bad_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, 32'h0, sq.size() + rq.size());
    end
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // result watcher: oldest note against whatever the design hands out
  always @(posedge clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (sq.size() > 0) cmp64(sq.pop_front(), {oa, ob, oc, od});
      else begin
        bad_count++;
        $display("BAD t=%0t exp=%h got=%h", $time, 64'h0, {oa, ob, oc, od});
      end
    end
    if (rd_dp === 1'b1 && hreadyout === 1'b1) cmp32(rq.pop_front(), hrdata);
    if (rd_dp === 1'b1 && hreadyout === 1'b1) cmp32(32'h0, {31'h0, hresp});
  end

  // sink stalls at random so the two-entry buffer really backs up
  always @(posedge clk) out_ready <= !stall && ($urandom_range(3) != 0);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // cut a hang short: 20000 cycles, far beyond the expected few hundred cycles
  initial begin
    #400000;
    bad_count++;
    final_report();
  end

  initial begin
    void'($urandom(32'h623f45af));
    {rst_n, hsel, hwrite, in_valid, rd_dp, stall, fixed} = '0;
    {htrans, haddr, hwdata, ia, ib, ic, id} = '0;
    mreg = '{default: 16'h0};
    mreg[IQCAB_IDX_A_GAIN] = 16'h0400;
    mreg[IQCAB_IDX_B_GAIN] = 16'h0400;
    mreg[IQCAB_IDX_DLY_GAIN] = IQCAB_DLY_GAIN_RST;
    mreg[IQCAB_IDX_SYNC_EN] = 16'h0001;
    ga = 1024;
    gb = 1024;
    ph = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) ahb(1'b0, regs[i], 16'h0);
    send(4);
    ahb(1'b1, IQCAB_IDX_A_GAIN, 16'h0600);
    ahb(1'b1, IQCAB_IDX_B_GAIN, 16'h0200);
    send(3);
    ahb(1'b1, IQCAB_IDX_PHASE, 16'h0800);
    send(3);
    // auto-sync off: the phase write must not load anything
    ahb(1'b1, IQCAB_IDX_SYNC_EN, 16'h0000);
    ahb(1'b1, IQCAB_IDX_A_GAIN, 16'h0400);
    ahb(1'b1, IQCAB_IDX_PHASE, 16'h0400);
    send(3);
    ahb(1'b1, IQCAB_IDX_SYNC_EN, 16'h0001);
    ahb(1'b1, IQCAB_IDX_PHASE, 16'h0400);
    send(3);
    // every lag pair, D gain unity, quarter or zero; drained first as lags act at once
    for (int i = 0; i < 16; i++) begin
      drain();
      ahb(1'b1, IQCAB_IDX_DLY_GAIN, {i[3:2], i[1:0], 1'b0,
          (i[0] ? 11'h100 : (i[2] ? 11'h000 : 11'h400))});
      send(5);
    end
    // directed corners: phase of minus one half on a fixed B, then zero A gain
    ahb(1'b1, IQCAB_IDX_A_GAIN, 16'h0400);
    ahb(1'b1, IQCAB_IDX_PHASE, 16'h0800);
    fixed = 1'b1;
    send(2);
    ahb(1'b1, IQCAB_IDX_A_GAIN, 16'h0000);
    ahb(1'b1, IQCAB_IDX_PHASE, 16'h0000);
    send(2);
    fixed = 1'b0;
    ahb(1'b1, IQCAB_IDX_NONE, 16'hffff);
    for (int i = 0; i < 6; i++) ahb(1'b0, regs[i], 16'h0);
    drain();
    stall = 1'b1;
    send(2);
    repeat (2) @(posedge clk);
    cmp32(32'h0, {31'h0, in_ready});
    stall = 1'b0;
    send(20);
    drain();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
